// ===== logic/nv_access_pkg.sv
// Package for the byte-wide nonvolatile store access controller.
// Holds the APB register map, field positions, reset values and timing counts.
// Assumes a 40 MHz system clock and 32-bit APB data with one register per word.

package nv_access_pkg;

	// System clock period in picoseconds (40 MHz)
	localparam int unsigned CLK_PERIOD_PS = 25000;

	// Least time of one read cycle, in nanoseconds
	localparam int unsigned READ_TIME_NS  = 100;
	// Read cycle in clock cycles, rounded up, never below one
	localparam int unsigned READ_CYCLES_RAW =
		(READ_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned READ_CYCLES = (READ_CYCLES_RAW < 1) ? 1 : READ_CYCLES_RAW;

	// Rising edges of the write timer that make one write cycle
	localparam int unsigned WRITE_TICKS = 4;

	// APB byte addresses of the registers
	localparam logic [7:0] LOCATION_OFS  = 8'h00; // nv_location_reg
	localparam logic [7:0] BYTE_OFS      = 8'h04; // nv_byte_reg
	localparam logic [7:0] PTR1_LOW_OFS  = 8'h08; // pointer1_low
	localparam logic [7:0] PTR1_HIGH_OFS = 8'h0c; // pointer1_high
	localparam logic [7:0] PTR2_HIGH_OFS = 8'h10; // pointer2_high
	localparam logic [7:0] PORT1_OFS     = 8'h14; // indirect_port1
	localparam logic [7:0] IRQ_EN_OFS    = 8'h18; // interrupt enables
	localparam logic [7:0] IRQ_FLAG_OFS  = 8'h1c; // interrupt request flags
	localparam logic [7:0] STATUS_OFS    = 8'h20; // engine status

	// Indirect location of the control register
	localparam logic [7:0] CTRL_SECTOR   = 8'h01;
	localparam logic [7:0] CTRL_LOCATION = 8'h3e;

	// Control register fields
	localparam int unsigned CTRL_READ_START  = 0;
	localparam int unsigned CTRL_READ_PERMIT = 1;
	localparam int unsigned CTRL_WRITE_START = 2;
	localparam int unsigned CTRL_WRITE_PERMIT = 3;

	// Interrupt enable fields
	localparam int unsigned IRQ_NV_EN     = 0;
	localparam int unsigned IRQ_MF_EN     = 1;
	localparam int unsigned IRQ_GLOBAL_EN = 2;

	// Interrupt flag fields
	localparam int unsigned FLAG_NV = 0;
	localparam int unsigned FLAG_MF = 1;

	// Status fields
	localparam int unsigned STAT_BUSY   = 0;
	localparam int unsigned STAT_FAILED = 1;

	// Reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] CTRL_RST = 4'h0;
	localparam logic [2:0] IRQ_EN_RST = 3'h0;

	// Engine states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_READ  = 3'b010,
		ST_WRITE = 3'b100
	} engine_e;

endpackage : nv_access_pkg

// ===== logic/nv_access_ctrl.sv
// Byte-wide nonvolatile store with read/write sequencing behind an APB slave.
// Assumes one 40 MHz clock, an asynchronous active-low reset, a write timer
// pin from a free-running asynchronous oscillator, and a core-side sleep level.
//
// Function
// - read start with permit fetches addressed byte
// - read start without permit is ignored
// - read end clears start, byte readable
// - byte register holds until next operation
// - write start without permit does nothing
// - write length set by asynchronous timer
// - write end clears write start bit
// - write permit clears at power-on
// - pointer high bytes clear at power-on
// - write end sets both request flags
// - interrupt needs all three enables set
// - servicing clears only multi-function flag
// - array is 256 locations of eight bits
// - both start bits never set together
// - control reachable only via sector 1, 3eh

`timescale 1ns/1ps
`default_nettype none

module nv_access_ctrl #(
	parameter int unsigned DEPTH       = 256,                        // Array locations
	parameter int unsigned READ_CYCLES = nv_access_pkg::READ_CYCLES, // Read length
	parameter int unsigned WRITE_TICKS = nv_access_pkg::WRITE_TICKS  // Timer edges per write
) (
	input  wire logic        REF_CLK,        // System clock, 40 MHz
	input  wire logic        RST_N,          // Asynchronous reset, active low
	input  wire logic        PSEL,           // APB select
	input  wire logic        PENABLE,        // APB access phase
	input  wire logic        PWRITE,         // APB direction, high writes
	input  wire logic [7:0]  PADDR,          // APB byte address
	input  wire logic [31:0] PWDATA,         // APB write data
	output logic      [31:0] PRDATA,         // APB read data
	output logic             PREADY,         // APB ready
	output logic             PSLVERR,        // APB error on unmapped address
	input  wire logic        WR_TIMER_TICK,  // Asynchronous write timer clock
	input  wire logic        LOW_POWER_REQ,  // Core enters idle or sleep
	input  wire logic        IRQ_SERVICED,   // Pulse: core vectors to this interrupt
	output logic             IRQ_REQ,        // Interrupt request to the core
	output logic             BUSY            // Read or write cycle in progress
);

	// Elaboration check on the parameters
	// array size, read length and timer edges per write
	if (DEPTH != 256 || READ_CYCLES < 1 || READ_CYCLES > 255
		|| WRITE_TICKS < 1 || WRITE_TICKS > 255) begin : g_chk
		$error("nv_access_ctrl: unsupported parameter values");
	end

	// Software-visible state
	logic [7:0]  location_q;   // nv_location_reg
	logic [7:0]  byte_q;       // nv_byte_reg
	logic [7:0]  ptr1_low_q;   // pointer1_low
	logic [7:0]  ptr1_high_q;  // pointer1_high
	logic [7:0]  ptr2_high_q;  // pointer2_high
	logic [3:0]  ctrl_q;       // nv_control_reg, low nibble
	logic [2:0]  irq_en_q;     // Interrupt enables
	logic [1:0]  flag_q;       // Interrupt request flags
	logic        failed_q;     // Last operation cut short by low power

	// Engine state
	nv_access_pkg::engine_e state_q; // Current operation
	logic [7:0]  op_addr_q;    // Location latched at start
	logic [7:0]  op_data_q;    // Byte latched at write start
	logic [7:0]  rd_cnt_q;     // Read cycle countdown
	logic [7:0]  tick_cnt_q;   // Timer edges left in a write

	// Storage array
	logic [7:0]  mem_q [DEPTH]; // Nonvolatile cells modelled as flops

	// Timer synchroniser
	logic [2:0]  tick_sync_q;  // Three-stage pin synchroniser
	logic        tick_lvl_q;   // Filtered timer level
	logic        tick_rise;    // Filtered rising edge

	// Bus decode
	logic        setup_ph;     // Setup cycle
	logic        acc_ph;       // Access cycle
	logic        wr_acc;       // Write taking effect now
	logic        mapped;       // Address is decoded
	logic        ctrl_sel;     // Indirect port points at control
	logic        ctrl_wr;      // Control register written now
	logic [7:0]  rd_mux;       // Read data before the output flop

	// Start decode
	logic        rd_start;     // Read cycle begins
	logic        wr_start;     // Write cycle begins
	logic        rd_done;      // Read cycle ends
	logic        wr_done;      // Write cycle ends
	logic        abort;        // Operation cut by low power

	// APB phases
	assign setup_ph = PSEL & ~PENABLE;
	assign acc_ph   = PSEL & PENABLE;
	assign wr_acc   = acc_ph & PWRITE;

	// Address decode
	always_comb begin
		unique case (PADDR)
			nv_access_pkg::LOCATION_OFS,
			nv_access_pkg::BYTE_OFS,
			nv_access_pkg::PTR1_LOW_OFS,
			nv_access_pkg::PTR1_HIGH_OFS,
			nv_access_pkg::PTR2_HIGH_OFS,
			nv_access_pkg::PORT1_OFS,
			nv_access_pkg::IRQ_EN_OFS,
			nv_access_pkg::IRQ_FLAG_OFS,
			nv_access_pkg::STATUS_OFS: mapped = 1'b1;
			default:                   mapped = 1'b0;
		endcase
	end

	assign ctrl_sel = (ptr1_high_q == nv_access_pkg::CTRL_SECTOR)
		&& (ptr1_low_q == nv_access_pkg::CTRL_LOCATION);
	assign ctrl_wr  = wr_acc && (PADDR == nv_access_pkg::PORT1_OFS) && ctrl_sel;

	// Zero-wait slave; read data registered in the setup cycle
	assign PREADY  = 1'b1;
	assign PSLVERR = acc_ph & ~mapped;

	// Read multiplexer
	always_comb begin
		rd_mux = 8'h00;
		unique case (PADDR)
			nv_access_pkg::LOCATION_OFS:  rd_mux = location_q;
			nv_access_pkg::BYTE_OFS:      rd_mux = byte_q;
			nv_access_pkg::PTR1_LOW_OFS:  rd_mux = ptr1_low_q;
			nv_access_pkg::PTR1_HIGH_OFS: rd_mux = ptr1_high_q;
			nv_access_pkg::PTR2_HIGH_OFS: rd_mux = ptr2_high_q;
			nv_access_pkg::PORT1_OFS:     rd_mux = ctrl_sel ? {4'h0, ctrl_q} : 8'h00;
			nv_access_pkg::IRQ_EN_OFS:    rd_mux = {5'h00, irq_en_q};
			nv_access_pkg::IRQ_FLAG_OFS:  rd_mux = {6'h00, flag_q};
			nv_access_pkg::STATUS_OFS:    rd_mux = {6'h00, failed_q, BUSY};
			default:                      rd_mux = 8'h00;
		endcase
	end

	// Read data captured during setup, held through access
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			PRDATA <= 32'h0000_0000;
		end else if (setup_ph && !PWRITE) begin
			PRDATA <= {24'h00_0000, rd_mux};
		end
	end

	// Start requests decoded from a control write
	always_comb begin
		rd_start = 1'b0;
		wr_start = 1'b0;
		if (ctrl_wr && state_q == nv_access_pkg::ST_IDLE) begin
			if (PWDATA[nv_access_pkg::CTRL_READ_START]
				&& PWDATA[nv_access_pkg::CTRL_WRITE_START]) begin
				rd_start = 1'b0;
				wr_start = 1'b0;
			end else begin
				rd_start = PWDATA[nv_access_pkg::CTRL_READ_START]
					& ctrl_q[nv_access_pkg::CTRL_READ_PERMIT];
				wr_start = PWDATA[nv_access_pkg::CTRL_WRITE_START]
					& ctrl_q[nv_access_pkg::CTRL_WRITE_PERMIT];
			end
		end
	end

	// Completion and abort events
	assign abort   = LOW_POWER_REQ && state_q != nv_access_pkg::ST_IDLE;
	assign rd_done = !abort && state_q == nv_access_pkg::ST_READ && rd_cnt_q == 8'h01;
	assign wr_done = !abort && state_q == nv_access_pkg::ST_WRITE && tick_rise
		&& tick_cnt_q == 8'h01;

	// Timer pin synchroniser, three stages
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_sync_q <= 3'h0;
		end else begin
			tick_sync_q <= {tick_sync_q[1:0], WR_TIMER_TICK};
		end
	end

	// Filtered level moves once stages two and three agree
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tick_lvl_q <= 1'b0;
		end else if (tick_sync_q[1] == tick_sync_q[2]) begin
			tick_lvl_q <= tick_sync_q[2];
		end
	end

	assign tick_rise = (tick_sync_q[1] == tick_sync_q[2]) & tick_sync_q[2] & ~tick_lvl_q;

	// Engine state and counters
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_q    <= nv_access_pkg::ST_IDLE;
			op_addr_q  <= 8'h00;
			op_data_q  <= 8'h00;
			rd_cnt_q   <= 8'h00;
			tick_cnt_q <= 8'h00;
		end else begin
			unique case (state_q)
				// Waiting for a start
				nv_access_pkg::ST_IDLE: begin
					if (rd_start) begin
						state_q   <= nv_access_pkg::ST_READ;
						op_addr_q <= location_q;
						rd_cnt_q  <= 8'(READ_CYCLES);
					end else if (wr_start) begin
						state_q    <= nv_access_pkg::ST_WRITE;
						op_addr_q  <= location_q;
						op_data_q  <= byte_q;
						tick_cnt_q <= 8'(WRITE_TICKS);
					end
				end
				// Fixed-length fetch
				nv_access_pkg::ST_READ: begin
					if (abort || rd_done) begin
						state_q <= nv_access_pkg::ST_IDLE;
					end else begin
						rd_cnt_q <= rd_cnt_q - 8'h01;
					end
				end
				nv_access_pkg::ST_WRITE: begin
					if (abort || wr_done) begin
						state_q <= nv_access_pkg::ST_IDLE;
					end else if (tick_rise) begin
						tick_cnt_q <= tick_cnt_q - 8'h01;
					end
				end
				default: begin
					state_q <= nv_access_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (wr_done) begin
			mem_q[op_addr_q] <= op_data_q;
		end
	end

	// Direct registers written by software
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			location_q <= 8'h00;
			ptr1_low_q <= 8'h00;
			ptr1_high_q <= 8'h00;
			ptr2_high_q <= 8'h00;
			irq_en_q    <= nv_access_pkg::IRQ_EN_RST;
		end else if (wr_acc) begin
			unique case (PADDR)
				nv_access_pkg::LOCATION_OFS:  location_q  <= PWDATA[7:0];
				nv_access_pkg::PTR1_LOW_OFS:  ptr1_low_q  <= PWDATA[7:0];
				nv_access_pkg::PTR1_HIGH_OFS: ptr1_high_q <= PWDATA[7:0];
				nv_access_pkg::PTR2_HIGH_OFS: ptr2_high_q <= PWDATA[7:0];
				nv_access_pkg::IRQ_EN_OFS:    irq_en_q    <= PWDATA[2:0];
				default:                      ;
			endcase
		end
	end

	// Byte register: software load or read result
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			byte_q <= nv_access_pkg::BYTE_RST;
		end else if (rd_done) begin
			byte_q <= mem_q[op_addr_q];
		end else if (wr_acc && PADDR == nv_access_pkg::BYTE_OFS) begin
			byte_q <= PWDATA[7:0];
		end
	end

	// Control register: permits, starts and hardware clears
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= nv_access_pkg::CTRL_RST;
		end else begin
			if (ctrl_wr) begin
				ctrl_q[nv_access_pkg::CTRL_READ_PERMIT]  <=
					PWDATA[nv_access_pkg::CTRL_READ_PERMIT];
				ctrl_q[nv_access_pkg::CTRL_WRITE_PERMIT] <=
					PWDATA[nv_access_pkg::CTRL_WRITE_PERMIT];
			end
			if (rd_start) begin
				ctrl_q[nv_access_pkg::CTRL_READ_START] <= 1'b1;
			end else if (rd_done || (abort && state_q == nv_access_pkg::ST_READ)) begin
				ctrl_q[nv_access_pkg::CTRL_READ_START] <= 1'b0;
			end
			if (wr_start) begin
				ctrl_q[nv_access_pkg::CTRL_WRITE_START] <= 1'b1;
			end else if (wr_done || (abort && state_q == nv_access_pkg::ST_WRITE)) begin
				ctrl_q[nv_access_pkg::CTRL_WRITE_START] <= 1'b0;
			end
		end
	end

	// Interrupt request flags; set wins over any clear
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			flag_q <= 2'h0;
		end else begin
			if (wr_done) begin
				flag_q[nv_access_pkg::FLAG_NV] <= 1'b1;
			end else if (wr_acc && PADDR == nv_access_pkg::IRQ_FLAG_OFS
				&& PWDATA[nv_access_pkg::FLAG_NV]) begin
				flag_q[nv_access_pkg::FLAG_NV] <= 1'b0;
			end
			if (wr_done) begin
				flag_q[nv_access_pkg::FLAG_MF] <= 1'b1;
			end else if (IRQ_SERVICED || (wr_acc && PADDR == nv_access_pkg::IRQ_FLAG_OFS
				&& PWDATA[nv_access_pkg::FLAG_MF])) begin
				flag_q[nv_access_pkg::FLAG_MF] <= 1'b0;
			end
		end
	end

	// Failure marker for an operation cut short; cleared by the next start
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			failed_q <= 1'b0;
		end else if (abort) begin
			failed_q <= 1'b1;
		end else if (rd_start || wr_start) begin
			failed_q <= 1'b0;
		end
	end

	assign IRQ_REQ = flag_q[nv_access_pkg::FLAG_NV] & flag_q[nv_access_pkg::FLAG_MF]
		& irq_en_q[nv_access_pkg::IRQ_NV_EN] & irq_en_q[nv_access_pkg::IRQ_MF_EN]
		& irq_en_q[nv_access_pkg::IRQ_GLOBAL_EN];

	// Engine activity
	assign BUSY = (state_q != nv_access_pkg::ST_IDLE);

endmodule : nv_access_ctrl

`default_nettype wire

// ===== verif/nv_access_ctrl_assertions.sv
// Checker for the nonvolatile access controller, bound to its top module.
// Assumes the APB map of nv_access_pkg and shadows software writes itself.
`timescale 1ns/1ps
`default_nettype none
module nv_access_ctrl_assertions #(
	parameter int unsigned READ_CYCLES = 4 // Read length in clocks
) (
	input wire logic        REF_CLK,       // System clock
	input wire logic        RST_N,         // Reset, active low
	input wire logic        PSEL,          // APB select
	input wire logic        PENABLE,       // APB access phase
	input wire logic        PWRITE,        // APB direction
	input wire logic [7:0]  PADDR,         // APB address
	input wire logic [31:0] PWDATA,        // APB write data
	input wire logic        LOW_POWER_REQ, // Sleep request
	input wire logic        IRQ_SERVICED,  // Vector taken
	input wire logic        IRQ_REQ,       // Interrupt request
	input wire logic        BUSY           // Operation running
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	logic       wr_any;  // APB write in access phase
	logic       idle_go; // Control write while idle and awake
	logic [7:0] lo_q;    // Shadow pointer low
	logic [7:0] hi_q;    // Shadow pointer high
	logic [1:0] perm_q;  // Shadow permits, write and read
	logic [2:0] en_q;    // Shadow interrupt enables
	logic [1:0] op_q;    // Running kind, write and read
	logic [7:0] len_q;   // Busy cycles so far
	assign wr_any = PSEL && PENABLE && PWRITE;
	assign idle_go = wr_any && PADDR == nv_access_pkg::PORT1_OFS && hi_q == 8'h01
		&& lo_q == 8'h3e && !BUSY && !LOW_POWER_REQ;
	// Track software registers and the kind of operation in flight
	always_ff @(posedge REF_CLK or negedge RST_N) begin
		if (!RST_N) begin
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			perm_q <= 2'h0;
			en_q <= 3'h0;
			op_q <= 2'h0;
			len_q <= 8'h00;
		end else begin
			if (wr_any && PADDR == nv_access_pkg::PTR1_LOW_OFS) lo_q <= PWDATA[7:0];
			if (wr_any && PADDR == nv_access_pkg::PTR1_HIGH_OFS) hi_q <= PWDATA[7:0];
			if (wr_any && PADDR == nv_access_pkg::IRQ_EN_OFS) en_q <= PWDATA[2:0];
			if (wr_any && PADDR == nv_access_pkg::PORT1_OFS && hi_q == 8'h01 && lo_q == 8'h3e)
				perm_q <= {PWDATA[3], PWDATA[1]};
			if (!BUSY) op_q <= idle_go ? {PWDATA[2] & perm_q[1], PWDATA[0] & perm_q[0]} : 2'h0;
			len_q <= BUSY ? len_q + 8'h01 : 8'h00;
		end
	end
	read_go_a: assert property (idle_go && perm_q[0] && PWDATA[0] && !PWDATA[2] |=> BUSY)
		else $error("permitted read start did not begin");
	read_gate_a: assert property (idle_go && !perm_q[0] && PWDATA[3:0] == 4'h1 |=> !BUSY)
		else $error("read ran without permit");
	read_len_a: assert property ($fell(BUSY) && op_q[0] && !$past(LOW_POWER_REQ)
		|-> len_q == READ_CYCLES) else $error("read length wrong");
	write_gate_a: assert property (idle_go && !perm_q[1] && PWDATA[3:0] == 4'h4 |=> !BUSY)
		else $error("write ran without permit");
	write_end_a: assert property (idle_go && perm_q[1] && PWDATA[2:0] == 3'b100
		|=> BUSY ##[1:200] !BUSY) else $error("write did not run and end");
	start_pair_a: assert property (idle_go && PWDATA[0] && PWDATA[2] |=> !BUSY)
		else $error("double start was taken");
	sleep_abort_a: assert property (BUSY && LOW_POWER_REQ |=> !BUSY)
		else $error("sleep did not stop operation");
	irq_gate_a: assert property (IRQ_REQ |-> en_q == 3'b111)
		else $error("interrupt with an enable clear");
	write_flag_a: assert property ($fell(BUSY) && op_q[1] && !$past(LOW_POWER_REQ)
		&& en_q == 3'b111 |-> IRQ_REQ) else $error("write end raised no request");
	mf_clear_a: assert property (IRQ_SERVICED && !BUSY && !wr_any |=> !IRQ_REQ)
		else $error("service left request up");
	reset_quiet_a: assert property ($rose(RST_N) |-> !BUSY && !IRQ_REQ)
		else $error("activity right after reset");
	// Main scenarios reached
	cover property (idle_go && perm_q[0] && PWDATA[0] && !PWDATA[2]);
	cover property (BUSY && LOW_POWER_REQ);
	cover property (IRQ_SERVICED && IRQ_REQ);
endmodule : nv_access_ctrl_assertions
bind nv_access_ctrl nv_access_ctrl_assertions #(.READ_CYCLES(READ_CYCLES)) i_chk (
	.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
	.PADDR(PADDR), .PWDATA(PWDATA), .LOW_POWER_REQ(LOW_POWER_REQ),
	.IRQ_SERVICED(IRQ_SERVICED), .IRQ_REQ(IRQ_REQ), .BUSY(BUSY));
`default_nettype wire

// ===== verif/nv_core_model.sv
// Core model: the application program reaching the controller over APB.
// Assumes each task is entered just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module nv_core_model (
	input  wire logic        clk,     // System clock
	input  wire logic        pready,  // APB ready
	input  wire logic [31:0] prdata,  // APB read data
	input  wire logic        pslverr, // APB error
	output logic             psel,    // APB select
	output logic             penable, // APB access phase
	output logic             pwrite,  // APB direction
	output logic      [7:0]  paddr,   // APB address
	output logic      [31:0] pwdata   // APB write data
);
	localparam logic [7:0] PORT = nv_access_pkg::PORT1_OFS; // Indirect port
	logic [31:0] rdata; // Data of the last transfer
	logic        rerr;  // Error of the last transfer
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// One transfer; select stays up so another may follow at once
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		rerr = pslverr;
		penable <= 1'b0;
	endtask : xfer
	// Bus released for one cycle
	task automatic idle();
		psel <= 1'b0;
		@(posedge clk);
	endtask : idle
	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		idle();
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
		idle();
	endtask : reg_rd
	// Pointer aimed at the control register
	task automatic aim();
		xfer(1'b1, nv_access_pkg::PTR1_LOW_OFS, 32'h3e);
		xfer(1'b1, nv_access_pkg::PTR1_HIGH_OFS, 32'h1);
	endtask : aim
	task automatic poll(input int b);
		do xfer(1'b0, PORT, 32'h0); while (rdata[b] !== 1'b0);
		idle();
	endtask : poll
	// Write sequence; enables en restored once started
	task automatic nv_write(input logic [7:0] loc, input logic [7:0] dat, input logic [2:0] en);
		xfer(1'b1, nv_access_pkg::LOCATION_OFS, {24'h0, loc});
		xfer(1'b1, nv_access_pkg::BYTE_OFS, {24'h0, dat});
		aim();
		xfer(1'b1, nv_access_pkg::IRQ_EN_OFS, {29'h0, en & 3'b011});
		xfer(1'b1, PORT, 32'h8);
		xfer(1'b1, PORT, 32'hc);
		xfer(1'b1, nv_access_pkg::IRQ_EN_OFS, {29'h0, en});
		idle();
	endtask : nv_write
	// Read sequence; byte left in rdata
	task automatic nv_read(input logic [7:0] loc);
		xfer(1'b1, nv_access_pkg::LOCATION_OFS, {24'h0, loc});
		aim();
		xfer(1'b1, PORT, 32'h2);
		xfer(1'b1, PORT, 32'h3);
		poll(0);
		reg_rd(nv_access_pkg::BYTE_OFS);
	endtask : nv_read
endmodule : nv_core_model
`default_nettype wire

// ===== verif/eeprom_byte_access_ctrl_tb.sv
// Testbench: core model drives the controller; a byte map predicts results.
// Assumes default read and write lengths and a free timer pin.
`timescale 1ns/1ps
`default_nettype none
module eeprom_byte_access_ctrl_tb;
	localparam logic [7:0] PORT = nv_access_pkg::PORT1_OFS;    // Indirect port
	localparam logic [7:0] FLAG = nv_access_pkg::IRQ_FLAG_OFS; // Request flags
	logic        ref_clk;  // System clock
	logic        rst_n;    // Reset, active low
	logic        tick;     // Write timer pin
	logic        low_pwr;  // Sleep request
	logic        serviced; // Vector pulse
	wire logic   psel, penable, pwrite, pready, pslverr, irq_req, busy;
	wire logic [7:0]  paddr;  // APB address
	wire logic [31:0] pwdata; // APB write data
	wire logic [31:0] prdata; // APB read data
	logic [7:0]  mem [int];   // Expected array contents
	logic [7:0]  loc;         // Location under test
	logic [7:0]  dat;         // Byte under test
	logic [7:0]  byte_m;      // Expected byte register
	int          n_fail;      // Mismatches
	int          checked;     // Comparisons
	nv_access_ctrl i_nv_access_ctrl (.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .WR_TIMER_TICK(tick), .LOW_POWER_REQ(low_pwr),
		.IRQ_SERVICED(serviced), .IRQ_REQ(irq_req), .BUSY(busy));
	nv_core_model i_core (.clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
	// Compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wrap_up();
		if (n_fail == 0 && checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : wrap_up
	// Clocks: system 25 ns, timer 97 ns unrelated
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		tick = 1'b0;
		#7;
		forever #48.5 tick = ~tick;
	end
	// Watchdog cuts a hang short
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		low_pwr = 1'b0;
		serviced = 1'b0;
		n_fail = 0;
		checked = 0;
		byte_m = 8'h00;
		void'($urandom(28930));
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		// Every mapped word clears at power-on
		for (int i = 0; i < 9; i++) begin
			i_core.reg_rd(8'(4 * i));
			chk(i_core.rdata, 32'h0);
		end
		i_core.reg_rd(8'h24);
		chk({31'h0, i_core.rerr}, 32'h1);
		// Control out of reach while pointer high is zero
		i_core.reg_wr(nv_access_pkg::PTR1_LOW_OFS, 32'h3e);
		i_core.reg_wr(PORT, 32'h2);
		i_core.reg_wr(nv_access_pkg::PTR1_HIGH_OFS, 32'h1);
		i_core.reg_rd(PORT);
		chk(i_core.rdata, 32'h0);
		// Starts without permit, and both starts together, stay idle
		i_core.reg_wr(PORT, 32'h1);
		chk({31'h0, busy}, 32'h0);
		i_core.reg_wr(PORT, 32'h4);
		chk({31'h0, busy}, 32'h0);
		i_core.reg_wr(PORT, 32'ha);
		i_core.reg_wr(PORT, 32'h5);
		chk({31'h0, busy}, 32'h0);
		// Writes under every enable mix, with a read start while busy
		for (int i = 0; i < 8; i++) begin
			loc = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			dat = 8'($urandom);
			i_core.nv_write(loc, dat, 3'(i));
			i_core.reg_wr(PORT, 32'hb);
			i_core.poll(2);
			chk(i_core.rdata, 32'ha);
			mem[loc] = dat;
			byte_m = dat;
			chk({31'h0, irq_req}, {31'h0, i == 7});
			i_core.reg_rd(FLAG);
			chk(i_core.rdata, 32'h3);
			serviced <= 1'b1;
			@(posedge ref_clk);
			serviced <= 1'b0;
			i_core.reg_rd(FLAG);
			chk(i_core.rdata, 32'h1);
			i_core.reg_wr(FLAG, 32'h1);
		end
		// Sleep during a write leaves the cell untouched
		i_core.nv_write(8'h00, ~mem[0], 3'h0);
		low_pwr <= 1'b1;
		@(posedge ref_clk);
		low_pwr <= 1'b0;
		i_core.poll(2);
		i_core.reg_rd(nv_access_pkg::STATUS_OFS);
		chk(i_core.rdata, 32'h2);
		// Read back every stored byte
		foreach (mem[k]) begin
			i_core.nv_read(k[7:0]);
			chk(i_core.rdata, {24'h0, mem[k]});
			byte_m = mem[k];
		end
		repeat (30) @(posedge ref_clk);
		i_core.reg_rd(nv_access_pkg::BYTE_OFS);
		chk(i_core.rdata, {24'h0, byte_m});
		wrap_up();
	end
endmodule : eeprom_byte_access_ctrl_tb
`default_nettype wire
